// ===== pto_map.svh
`ifndef PTO_MAP_SVH
`define PTO_MAP_SVH

// Register byte offsets
`define PTO_OFF_CTRL       8'h00
`define PTO_OFF_STATUS     8'h04
`define PTO_OFF_TGT0       8'h08
`define PTO_OFF_NUM0       8'h0C
`define PTO_OFF_TGT1       8'h10
`define PTO_OFF_NUM1       8'h14
`define PTO_OFF_EXTRA      8'h18
`define PTO_OFF_CNTA_LO    8'h1C
`define PTO_OFF_CNTA_HI    8'h20
`define PTO_OFF_CNTB_LO    8'h24
`define PTO_OFF_CNTB_HI    8'h28
`define PTO_OFF_SE0        8'h2C
`define PTO_OFF_RAMP0      8'h30
`define PTO_OFF_DEC0       8'h34
`define PTO_OFF_DEC1       8'h38
`define PTO_OFF_SE1        8'h3C
`define PTO_OFF_RAMP1      8'h40

// Control register bit positions
`define PTO_CB_START0      0
`define PTO_CB_START1      1
`define PTO_CB_STOP0       2
`define PTO_CB_STOP1       3
`define PTO_CB_DIR0        4
`define PTO_CB_DIR1        5
`define PTO_CB_SEP0        6
`define PTO_CB_SEP1        7
`define PTO_CB_EXTRA_EN    8
`define PTO_CB_HOME0       9
`define PTO_CB_RESTART     10

// Reset values
`define PTO_RST_FREQ       16'h0064
`define PTO_RST_TIME       16'h0064
`define PTO_RST_EXTRA      16'h0000
`define PTO_RST_COUNT      32'h0000_0000

// Timing: ramp times count in milliseconds
`define PTO_CLK_NS         25
`define PTO_TICK_MS        1
`define PTO_CYC_PER_MS     ((`PTO_TICK_MS * 1000000) / `PTO_CLK_NS)

`endif

// ===== pto_pkg.sv
package pto_pkg;

    typedef enum logic [1:0] {PH_IDLE, PH_ACCEL, PH_CRUISE, PH_DECEL} pto_phase_t;

    typedef struct packed {
        pto_phase_t  phase;
        logic [15:0] freq;
        logic [31:0] err;
        logic [31:0] acc;
        logic [31:0] left;
        logic [31:0] up;
        logic        lvl;
        logic        step;
        logic        home_wait;
    } pto_gen_st_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic        hit;
        logic        wr_pend;
        logic        rd_pend;
        logic [31:0] rdata;
        logic        ready;
        logic [5:0]  flags;
        logic [3:0]  cmd;
        logic [15:0] tgt0;
        logic [15:0] tgt1;
        logic [31:0] num0;
        logic [31:0] num1;
        logic [15:0] extra;
        logic [15:0] se0;
        logic [15:0] ramp0;
        logic [15:0] dec0;
        logic [15:0] dec1;
        logic [15:0] se1;
        logic [15:0] ramp1;
        logic [31:0] cnt_a;
        logic [31:0] cnt_b;
        logic [3:0]  pins;
        logic        z_prev;
        logic        z_edge;
    } pto_top_st_t;

endpackage

// ===== pto_chan_if.sv
`timescale 1ns/1ps
interface pto_chan_if;
    logic        start;
    logic        stop;
    logic        home_mode;
    logic        z_edge;
    logic        extra_en;
    logic [15:0] start_freq;
    logic [15:0] target_freq;
    logic [15:0] ramp_ms;
    logic [15:0] decel_ms;
    logic [15:0] extra_cnt;
    logic [31:0] pulses;
    logic        lvl;
    logic        step;
    logic        busy;

    modport gen (
        input  start, stop, home_mode, z_edge, extra_en, start_freq, target_freq,
        input  ramp_ms, decel_ms, extra_cnt, pulses,
        output lvl, step, busy
    );
    modport ctl (
        output start, stop, home_mode, z_edge, extra_en, start_freq, target_freq,
        output ramp_ms, decel_ms, extra_cnt, pulses,
        input  lvl, step, busy
    );
endinterface

// ===== pto_sync2.sv
`timescale 1ns/1ps
module pto_sync2
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Asynchronous level in, synchronised level out
    input  wire logic async_in,
    output logic      sync_out
);
    logic [1:0] stage_reg;
    logic [1:0] stage_next;

    // Second stage alone reads the first
    always_comb
    begin
        stage_next = {stage_reg[0], async_in};
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            stage_reg <= 2'h0;
        else
            stage_reg <= stage_next;
    end

    assign sync_out = stage_reg[1];
endmodule

// ===== pto_ramp_gen.sv
`timescale 1ns/1ps
`include "pto_map.svh"
module pto_ramp_gen
    import pto_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `PTO_CYC_PER_MS
)
(
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  srst,
    // Channel settings and status
    pto_chan_if.gen    ch
);
    localparam logic [31:0] HZ  = 32'(CYC_PER_MS * 1000);
    localparam logic [31:0] CYC = 32'(CYC_PER_MS);

    pto_gen_st_t r;
    pto_gen_st_t n;
    logic [31:0] t_up;
    logic [31:0] t_dn;
    logic [31:0] acc_sum;
    logic [31:0] err_sum;
    logic [15:0] dfreq;

    ////////////////////////////////////////////////////////////////////////////
    // Phase accumulator toggles the line at twice the current frequency;
    // Bresenham error term steps the frequency by one Hz, so the slope is
    // linear but limited to one Hz per clock
    always_comb
    begin
        n       = r;
        n.step  = 1'b0;
        t_up    = 32'(ch.ramp_ms) * CYC;
        t_dn    = 32'(ch.decel_ms) * CYC;
        dfreq   = (ch.target_freq > ch.start_freq) ? 16'(ch.target_freq - ch.start_freq)
                                                   : 16'h0000;
        acc_sum = r.acc + {15'h0000, r.freq, 1'b0};
        err_sum = r.err + {16'h0000, dfreq};
        case (r.phase)
            PH_IDLE:
            begin
                if (ch.start && (ch.pulses != 32'h0000_0000 || ch.home_mode))
                begin
                    n.phase     = PH_ACCEL;
                    n.freq      = ch.start_freq;
                    n.left      = ch.pulses;
                    n.up        = 32'h0000_0000;
                    n.err       = 32'h0000_0000;
                    n.acc       = 32'h0000_0000;
                    n.lvl       = 1'b0;
                    n.home_wait = ch.home_mode;
                end
            end
            default:
            begin
                // Pulse edges
                if (acc_sum >= HZ)
                begin
                    n.acc = acc_sum - HZ;
                    if (r.lvl)
                        n.lvl = 1'b0;
                    else if (r.home_wait || r.left != 32'h0000_0000)
                    begin
                        n.lvl  = 1'b1;
                        n.step = 1'b1;
                        if (!r.home_wait)
                            n.left = r.left - 32'h0000_0001;
                        if (r.phase == PH_ACCEL)
                            n.up = r.up + 32'h0000_0001;
                    end
                end
                else
                    n.acc = acc_sum;
                // Linear ramp up and down
                if (r.phase == PH_ACCEL)
                begin
                    if (r.freq >= ch.target_freq)
                    begin
                        n.phase = PH_CRUISE;
                        n.err   = 32'h0000_0000;
                    end
                    else if (err_sum >= t_up)
                    begin
                        n.freq = r.freq + 16'h0001;
                        n.err  = err_sum - t_up;
                    end
                    else
                        n.err = err_sum;
                end
                else if (r.phase == PH_DECEL && r.freq > ch.start_freq)
                begin
                    if (err_sum >= t_dn)
                    begin
                        n.freq = r.freq - 16'h0001;
                        n.err  = err_sum - t_dn;
                    end
                    else
                        n.err = err_sum;
                end
                // Symmetric guess: brake once remaining is no more than pulses spent ramping
                if (!r.home_wait && r.phase != PH_DECEL && r.left <= r.up)
                begin
                    n.phase = PH_DECEL;
                    n.err   = 32'h0000_0000;
                end
                // Marker found: emit the extra pulses only when enabled
                if (r.home_wait && ch.z_edge)
                begin
                    n.home_wait = 1'b0;
                    n.left      = ch.extra_en ? {16'h0000, ch.extra_cnt}
                                              : 32'h0000_0000;
                    n.up        = 32'h0000_0000;
                end
                if ((!r.home_wait && r.left == 32'h0000_0000 && !r.lvl) || ch.stop)
                begin
                    n.phase = PH_IDLE;
                    n.lvl   = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            r       <= '0;
            r.phase <= PH_IDLE;
        end
        else
            r <= n;
    end

    assign ch.lvl  = r.lvl;
    assign ch.step = r.step;
    assign ch.busy = (r.phase != PH_IDLE);
endmodule

// ===== pto_top.sv
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "pto_map.svh"
// Functional notes
// - Channel two out-A pulse count, 32 bits, survives restart
// - Channel two out-B pulse count, 32 bits, restart clears
// - Channel one start/end frequency, default 100
// - Channel one ramp time, default 100
// - Channel one separate decel time when flagged
// - Channel two separate decel time when flagged
// - Channel two start/end frequency, default 100
// - Extra home pulses only while enable set
// - Channel two ramp time, default 100
module pto_top
    import pto_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `PTO_CYC_PER_MS
)
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Drive side
    input  wire logic        home_z_phase,
    output logic             first_chan_out_a,
    output logic             first_chan_out_b,
    output logic             second_chan_out_a,
    output logic             second_chan_out_b
);
    pto_top_st_t r;
    pto_top_st_t n;

    // Combinational helpers
    logic        z_sync;
    logic        wr_ctrl;
    logic        restart;
    logic [31:0] base_a;
    logic [31:0] base_b;
    logic [31:0] rd_word;
    logic [31:0] inc_a;
    logic [31:0] inc_b;

    // Control flag views
    logic        dir0;
    logic        dir1;
    logic        sep0;
    logic        sep1;

    pto_chan_if ch0();
    pto_chan_if ch1();

    ////////////////////////////////////////////////////////////////////////////
    // Marker input from the drive crosses into the clock domain first
    pto_sync2 u_zsync (
        .clock    (clock),
        .srst     (srst),
        .async_in (home_z_phase),
        .sync_out (z_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Channel generators
    pto_ramp_gen #(.CYC_PER_MS(CYC_PER_MS)) u_gen0 (
        .clock (clock),
        .srst  (srst),
        .ch    (ch0.gen)
    );

    pto_ramp_gen #(.CYC_PER_MS(CYC_PER_MS)) u_gen1 (
        .clock (clock),
        .srst  (srst),
        .ch    (ch1.gen)
    );

    // Settings into the generators
    assign dir0 = r.flags[0];
    assign dir1 = r.flags[1];

    assign sep0 = r.flags[2];
    assign sep1 = r.flags[3];

    // First channel settings
    assign ch0.start       = r.cmd[0];
    assign ch0.stop        = r.cmd[2];
    assign ch0.home_mode   = r.flags[5];
    assign ch0.z_edge      = r.z_edge;
    assign ch0.extra_en    = r.flags[4];
    assign ch0.extra_cnt   = r.extra;

    assign ch0.start_freq  = r.se0;
    assign ch0.target_freq = r.tgt0;
    assign ch0.ramp_ms     = r.ramp0;
    assign ch0.decel_ms    = sep0 ? r.dec0 : r.ramp0;
    assign ch0.pulses      = r.num0;

    // Second channel: no home search
    assign ch1.start       = r.cmd[1];
    assign ch1.stop        = r.cmd[3];
    assign ch1.home_mode   = 1'b0;
    assign ch1.z_edge      = 1'b0;
    assign ch1.extra_en    = 1'b0;
    assign ch1.extra_cnt   = 16'h0000;

    assign ch1.start_freq  = r.se1;
    assign ch1.target_freq = r.tgt1;
    assign ch1.ramp_ms     = r.ramp1;
    assign ch1.decel_ms    = sep1 ? r.dec1 : r.ramp1;
    assign ch1.pulses      = r.num1;

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; narrow registers read zero above bit 15
    always_comb
    begin
        rd_word = 32'h0000_0000;

        case (r.addr)
            `PTO_OFF_CTRL:
            begin
                rd_word[`PTO_CB_DIR0]     = r.flags[0];
                rd_word[`PTO_CB_DIR1]     = r.flags[1];
                rd_word[`PTO_CB_SEP0]     = r.flags[2];
                rd_word[`PTO_CB_SEP1]     = r.flags[3];
                rd_word[`PTO_CB_EXTRA_EN] = r.flags[4];
                rd_word[`PTO_CB_HOME0]    = r.flags[5];
            end
            `PTO_OFF_STATUS:  rd_word = {29'h0000_0000, z_sync, ch1.busy, ch0.busy};

            `PTO_OFF_TGT0:    rd_word = {16'h0000, r.tgt0};
            `PTO_OFF_NUM0:    rd_word = r.num0;
            `PTO_OFF_TGT1:    rd_word = {16'h0000, r.tgt1};
            `PTO_OFF_NUM1:    rd_word = r.num1;

            `PTO_OFF_EXTRA:   rd_word = {16'h0000, r.extra};

            `PTO_OFF_CNTA_LO: rd_word = {16'h0000, r.cnt_a[15:0]};
            `PTO_OFF_CNTA_HI: rd_word = {16'h0000, r.cnt_a[31:16]};

            `PTO_OFF_CNTB_LO: rd_word = {16'h0000, r.cnt_b[15:0]};
            `PTO_OFF_CNTB_HI: rd_word = {16'h0000, r.cnt_b[31:16]};

            `PTO_OFF_SE0:     rd_word = {16'h0000, r.se0};
            `PTO_OFF_RAMP0:   rd_word = {16'h0000, r.ramp0};
            `PTO_OFF_DEC0:    rd_word = {16'h0000, r.dec0};
            `PTO_OFF_DEC1:    rd_word = {16'h0000, r.dec1};
            `PTO_OFF_SE1:     rd_word = {16'h0000, r.se1};
            `PTO_OFF_RAMP1:   rd_word = {16'h0000, r.ramp1};
            default:          rd_word = 32'h0000_0000;
        endcase
        // Misaligned or out of range
        if (!r.hit)
            rd_word = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave, register writes, pulse counters and output pins.
    // Reads take one wait state so a write in the previous data phase is
    // already visible; writes complete with no wait.
    always_comb
    begin
        n        = r;
        // Command strobes last one cycle
        n.cmd    = 4'h0;
        // Marker edge for the home search
        n.z_prev = z_sync;
        n.z_edge = z_sync && !r.z_prev;

        wr_ctrl  = r.wr_pend && r.hit && (r.addr == `PTO_OFF_CTRL);
        restart  = wr_ctrl && hwdata[`PTO_CB_RESTART];
        // Count pulses by direction
        inc_a    = (ch1.step && !dir1) ? 32'h0000_0001 : 32'h0000_0000;
        inc_b    = (ch1.step && dir1) ? 32'h0000_0001 : 32'h0000_0000;
        base_a   = r.cnt_a;
        base_b   = r.cnt_b;

        // Address phase
        n.wr_pend = 1'b0;
        n.rd_pend = 1'b0;

        if (r.rd_pend)
        begin
            n.rdata = rd_word;
            n.ready = 1'b1;
        end
        else if (hsel && hready && htrans[1])
        begin
            n.addr    = haddr[7:0];
            n.hit     = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
            n.wr_pend = hwrite;
            n.rd_pend = !hwrite;
            n.ready   = hwrite;
        end

        // Data phase of a write
        if (r.wr_pend && r.hit)
        begin
            case (r.addr)
                `PTO_OFF_CTRL:
                begin
                    n.cmd   = {hwdata[`PTO_CB_STOP1], hwdata[`PTO_CB_STOP0],
                               hwdata[`PTO_CB_START1], hwdata[`PTO_CB_START0]};
                    n.flags = {hwdata[`PTO_CB_HOME0], hwdata[`PTO_CB_EXTRA_EN],
                               hwdata[`PTO_CB_SEP1], hwdata[`PTO_CB_SEP0],
                               hwdata[`PTO_CB_DIR1], hwdata[`PTO_CB_DIR0]};
                end

                `PTO_OFF_TGT0:    n.tgt0  = hwdata[15:0];
                `PTO_OFF_NUM0:    n.num0  = hwdata;
                `PTO_OFF_TGT1:    n.tgt1  = hwdata[15:0];
                `PTO_OFF_NUM1:    n.num1  = hwdata;

                `PTO_OFF_EXTRA:   n.extra = hwdata[15:0];

                `PTO_OFF_CNTA_LO: base_a[15:0]  = hwdata[15:0];
                `PTO_OFF_CNTA_HI: base_a[31:16] = hwdata[15:0];

                `PTO_OFF_CNTB_LO: base_b[15:0]  = hwdata[15:0];
                `PTO_OFF_CNTB_HI: base_b[31:16] = hwdata[15:0];

                `PTO_OFF_SE0:     n.se0   = hwdata[15:0];
                `PTO_OFF_RAMP0:   n.ramp0 = hwdata[15:0];
                `PTO_OFF_DEC0:    n.dec0  = hwdata[15:0];
                `PTO_OFF_DEC1:    n.dec1  = hwdata[15:0];
                `PTO_OFF_SE1:     n.se1   = hwdata[15:0];
                `PTO_OFF_RAMP1:   n.ramp1 = hwdata[15:0];
                default:          n.cmd   = 4'h0;
            endcase
        end

        // A pulse landing in the write cycle adds onto the written value
        n.cnt_a = base_a + inc_a;
        n.cnt_b = base_b + inc_b;

        // Software restart stands in for a power cycle: only the out-A count
        // is kept, everything unlatched goes back to its default
        if (restart)
        begin
            n.cmd   = 4'b1100;
            n.flags = 6'h00;
            n.num0  = 32'h0000_0000;
            n.num1  = 32'h0000_0000;
            n.tgt0  = 16'h0000;
            n.tgt1  = 16'h0000;

            n.extra = `PTO_RST_EXTRA;
            n.cnt_b = `PTO_RST_COUNT;

            n.se0   = `PTO_RST_FREQ;
            n.ramp0 = `PTO_RST_TIME;
            n.dec0  = `PTO_RST_TIME;
            n.dec1  = `PTO_RST_TIME;
            n.se1   = `PTO_RST_FREQ;
            n.ramp1 = `PTO_RST_TIME;
        end

        // Pins: channel line on A for forward, on B for reverse
        n.pins = {ch1.lvl && dir1, ch1.lvl && !dir1, ch0.lvl && dir0, ch0.lvl && !dir0};
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            r       <= '0;
            r.ready <= 1'b1;

            r.extra <= `PTO_RST_EXTRA;
            r.cnt_a <= `PTO_RST_COUNT;
            r.cnt_b <= `PTO_RST_COUNT;

            r.se0   <= `PTO_RST_FREQ;
            r.ramp0 <= `PTO_RST_TIME;
            r.dec0  <= `PTO_RST_TIME;
            r.dec1  <= `PTO_RST_TIME;
            r.se1   <= `PTO_RST_FREQ;
            r.ramp1 <= `PTO_RST_TIME;
        end
        else
            r <= n;
    end

    // Outputs from flip-flops, except hresp which is tied low
    assign hreadyout         = r.ready;
    assign hrdata            = r.rdata;
    assign hresp             = 1'b0;

    assign first_chan_out_a  = r.pins[0];
    assign first_chan_out_b  = r.pins[1];
    assign second_chan_out_a = r.pins[2];
    assign second_chan_out_b = r.pins[3];

endmodule

// ===== pto_properties.sv
`timescale 1ns/1ps
module pto_properties (
    // Clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // Bus side
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // Drive side
    input wire logic        first_chan_out_a,
    input wire logic        first_chan_out_b,
    input wire logic        second_chan_out_a,
    input wire logic        second_chan_out_b
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Read takes exactly one wait cycle, then data
    sequence s_rd_take;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence s_rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_one_wait: assert property (s_rd_take |=> s_rd_answer)
        else $error("read wait not one cycle");
    a_write_no_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write inserted a wait");
    a_ready_low_once: assert property (!hreadyout |=> hreadyout)
        else $error("ready low too long");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    // Read data may only change when a read completes
    a_data_held: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    a_reset_quiet: assert property ($fell(srst) |-> !first_chan_out_a && !second_chan_out_a
        && !first_chan_out_b && !second_chan_out_b && hrdata == 32'h0)
        else $error("outputs not quiet after reset");
    // Only one line of a channel carries pulses at a time
    a_chan1_one_line: assert property (!(first_chan_out_a && first_chan_out_b))
        else $error("both first channel lines high");
    a_chan2_one_line: assert property (!(second_chan_out_a && second_chan_out_b))
        else $error("both second channel lines high");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind pto_top pto_properties u_props (.clock(clock), .srst(srst), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .first_chan_out_a(first_chan_out_a), .first_chan_out_b(first_chan_out_b),
    .second_chan_out_a(second_chan_out_a), .second_chan_out_b(second_chan_out_b));

// ===== pto_drive_model.sv
`timescale 1ns/1ps
module pto_drive_model (
    // Clock
    input wire logic  clock,
    // Pulse lines, a/b of first then second channel
    input wire logic [3:0] lines,
    // Z-phase marker back to the block
    output logic      home_z_phase
);
    int unsigned pulses [4];
    logic [3:0]  prev;
    initial
    begin
        home_z_phase = 1'b0;
        prev = 4'h0;
        foreach (pulses[i]) pulses[i] = 0;
    end
    // One rising edge is one step of the drive
    always @(posedge clock)
    begin
        for (int i = 0; i < 4; i++)
            if (lines[i] && !prev[i]) pulses[i]++;
        prev <= lines;
    end
    // Marker held a few cycles so the two-flop synchroniser sees it
    task automatic mark_z();
        @(posedge clock);
        home_z_phase <= 1'b1;
        repeat (4) @(posedge clock);
        home_z_phase <= 1'b0;
    endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`include "pto_map.svh"
module tb_top;
    logic        clock, srst, hsel, hwrite, hreadyout, hresp, home_z_phase;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, seed, q;
    logic [3:0]  lines;
    logic [31:0] mdl [int];
    int          n_fail, check_count;
    int unsigned b [4];
    localparam logic [31:0] ST0 = 32'h1 << `PTO_CB_START0;
    localparam logic [31:0] ST1 = 32'h1 << `PTO_CB_START1;
    ////////////////////////////////////////////////////////////////////////////
    // Short ms so ramps fit in a short run
    pto_top #(.CYC_PER_MS(40)) dut (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .home_z_phase(home_z_phase),
        .first_chan_out_a(lines[0]), .first_chan_out_b(lines[1]),
        .second_chan_out_a(lines[2]), .second_chan_out_b(lines[3]));
    pto_drive_model drv (.clock(clock), .lines(lines), .home_z_phase(home_z_phase));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One single transfer; the next call lets an edge pass first
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clock);
        while (!hreadyout) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (!hreadyout) @(posedge clock);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
        if (mdl.exists(a)) mdl[a] = {16'h0, d[15:0]};
    endtask
    task automatic rc(input logic [7:0] a);
        bus(a, 1'b0, 32'h0);
        chk(q, mdl.exists(a) ? mdl[a] : 32'h0);
    endtask
    // Values that a restart or power-up puts back
    task automatic defaults();
        foreach (mdl[k]) if (k != `PTO_OFF_CNTA_LO && k != `PTO_OFF_CNTA_HI) mdl[k] = 32'h64;
        mdl[`PTO_OFF_EXTRA] = 32'h0;
        mdl[`PTO_OFF_CNTB_LO] = 32'h0;
        mdl[`PTO_OFF_CNTB_HI] = 32'h0;
    endtask
    task automatic idle();
        for (int i = 0; i < 3000; i++)
        begin
            bus(`PTO_OFF_STATUS, 1'b0, 32'h0);
            if (q[1:0] === 2'h0) break;
        end
        if (q[1:0] !== 2'h0) n_fail++;
    endtask
    task automatic go(input logic [7:0] tgt, input logic [31:0] ctl, input int n);
        foreach (b[i]) b[i] = drv.pulses[i];
        wr(tgt, 32'h3E8);
        wr(tgt + 8'h04, n);
        wr(`PTO_OFF_CTRL, ctl);
        idle();
    endtask
    task automatic addcnt(input logic [7:0] lo, input int n);
        logic [31:0] v;
        v = {mdl[lo + 8'h04][15:0], mdl[lo][15:0]} + n;
        mdl[lo] = {16'h0, v[15:0]};
        mdl[lo + 8'h04] = {16'h0, v[31:16]};
        rc(lo);
        rc(lo + 8'h04);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Watchdog well beyond the expected run
    initial
    begin
        repeat (90000) @(posedge clock);
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        srst = 1'b1; hsel = 1'b1; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
        seed = 32'hB9FE; n_fail = 0; check_count = 0;
        for (int a = `PTO_OFF_EXTRA; a <= `PTO_OFF_RAMP1; a += 4) mdl[a] = 32'h0;
        defaults();
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        foreach (mdl[k]) rc(k[7:0]);
        $display("test defaults done");
        // Random settings, an unmapped place, then a restart
        foreach (mdl[k]) wr(k[7:0], xs());
        wr(8'hF0, xs());
        rc(8'hF0);
        foreach (mdl[k]) rc(k[7:0]);
        wr(`PTO_OFF_CTRL, 32'h1 << `PTO_CB_RESTART);
        defaults();
        foreach (mdl[k]) rc(k[7:0]);
        $display("test retention done");
        // Fast ramps; out-a count sits just below a word carry
        for (int a = `PTO_OFF_SE0; a <= `PTO_OFF_RAMP1; a += 4) wr(8'(a), 32'h1);
        wr(`PTO_OFF_SE0, 32'h190);
        wr(`PTO_OFF_SE1, 32'h190);
        wr(`PTO_OFF_CNTA_LO, 32'hFFFE);
        go(`PTO_OFF_TGT1, ST1 | (32'h1 << `PTO_CB_SEP1), 5);
        chk(drv.pulses[2] - b[2], 32'h5);
        chk(drv.pulses[3] - b[3], 32'h0);
        addcnt(`PTO_OFF_CNTA_LO, 5);
        go(`PTO_OFF_TGT1, ST1 | (32'h1 << `PTO_CB_DIR1), 4);
        chk(drv.pulses[3] - b[3], 32'h4);
        addcnt(`PTO_OFF_CNTB_LO, 4);
        go(`PTO_OFF_TGT0, ST0 | (32'h1 << `PTO_CB_SEP0), 6);
        chk(drv.pulses[0] - b[0], 32'h6);
        chk(drv.pulses[1] - b[1], 32'h0);
        $display("test pulse runs done");
        // Home search, with and without extra pulses
        wr(`PTO_OFF_EXTRA, 32'h3);
        for (int en = 0; en < 2; en++)
        begin
            wr(`PTO_OFF_TGT0, 32'h3E8);
            wr(`PTO_OFF_CTRL, ST0 | (32'h1 << `PTO_CB_HOME0) | (en << `PTO_CB_EXTRA_EN)
                | (en << `PTO_CB_DIR0));
            repeat (400) @(posedge clock);
            b[en] = drv.pulses[en];
            drv.mark_z();
            idle();
            q = drv.pulses[en] - b[en];
            chk(32'(en ? (q >= 3 && q <= 4) : (q <= 1)), 32'h1);
        end
        wr(`PTO_OFF_CTRL, ST0 | (32'h1 << `PTO_CB_HOME0));
        wr(`PTO_OFF_CTRL, 32'h3 << `PTO_CB_STOP0);
        idle();
        $display("test home done");
        tally_and_finish();
    end
endmodule
